// File: logic/tcp_pkg.sv
package tcp_pkg;
    localparam int unsigned CH_NUM = 8;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned DIV_W = 7;
    localparam int unsigned PS_W = 3;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_FULL = 16'hffff;
    localparam logic [DIV_W-1:0] DIV_ZERO = 7'h00;
    localparam logic [DIV_W-1:0] DIV_ONE = 7'h01;
    localparam logic [DIV_W:0] MASK_ONE = 8'h01;
    // Edge and level select codes
    localparam logic [1:0] ELS_NONE = 2'b00;
    localparam logic [1:0] ELS_RISE_TOGGLE = 2'b01;
    localparam logic [1:0] ELS_FALL_CLEAR = 2'b10;
    localparam logic [1:0] ELS_BOTH_SET = 2'b11;
    localparam int unsigned ELS_POL_BIT = 0;
    // Channel mode codes, upper bit alone means edge PWM
    localparam logic [1:0] MODE_CAPTURE = 2'b00;
    localparam logic [1:0] MODE_COMPARE = 2'b01;
    localparam int unsigned MODE_PWM_BIT = 1;
    typedef enum logic [1:0] {
        CLK_OFF = 2'b00,
        CLK_BUS = 2'b01,
        CLK_FIXED = 2'b10,
        CLK_EXT = 2'b11
    } tcp_clk_src_t;
endpackage

// File: logic/tcp_edge_sync.sv
`timescale 1ns/1ps
module tcp_edge_sync (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Pin in, edges out
    input wire logic pin_i,
    output logic rise_o,
    output logic fall_o
);
    import tcp_pkg::*;
    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic last_q, last_d;

    always_comb
    begin
        meta_d = pin_i;
        sync_d = meta_q;
        last_d = sync_q;
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            last_q <= last_d;
        end
    end

    // Edges only from the settled stages
    assign rise_o = sync_q & ~last_q;
    assign fall_o = ~sync_q & last_q;
endmodule

// File: logic/tcp_prescaler.sv
`timescale 1ns/1ps
module tcp_prescaler (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Source and division
    input wire tcp_pkg::tcp_clk_src_t clock_source_select_i,
    input wire logic [tcp_pkg::PS_W-1:0] prescale_select_i,
    input wire logic fixed_clock_tick_i,
    input wire logic external_count_clock_i,
    // Control
    input wire logic run_i,
    input wire logic restart_i,
    // Counter advance pulse
    output logic count_tick_o
);
    import tcp_pkg::*;
    logic ext_rise;
    logic src_ev;
    logic [DIV_W-1:0] mask;
    logic [DIV_W-1:0] div_q, div_d;
    logic tick_q, tick_d;

    // Slow external clock, at most a quarter of core rate
    tcp_edge_sync u_ext_sync (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(external_count_clock_i),
        .rise_o(ext_rise),
        .fall_o()
    );

    always_comb
    begin
        unique case (clock_source_select_i)
            CLK_OFF: src_ev = 1'b0;
            CLK_BUS: src_ev = 1'b1;
            CLK_FIXED: src_ev = fixed_clock_tick_i;
            CLK_EXT: src_ev = ext_rise;
        endcase
        mask = DIV_W'((MASK_ONE << prescale_select_i) - MASK_ONE);
        div_d = div_q;
        tick_d = 1'b0;
        if (restart_i)
        begin
            div_d = DIV_ZERO;
        end
        else if (src_ev && run_i)
        begin
            if ((div_q & mask) == mask)
            begin
                div_d = DIV_ZERO;
                tick_d = 1'b1;
            end
            else
            begin
                div_d = div_q + DIV_ONE;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            div_q <= DIV_ZERO;
            tick_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            tick_q <= tick_d;
        end
    end

    assign count_tick_o = tick_q;
endmodule

// File: logic/tcp_timer.sv
`timescale 1ns/1ps
module tcp_timer (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Processor state
    input wire logic debug_halt_mode_i,
    input wire logic stop_mode_i,
    // Counter configuration
    input wire tcp_pkg::tcp_clk_src_t clock_source_select_i,
    input wire logic [tcp_pkg::PS_W-1:0] prescale_select_i,
    input wire logic center_align_select_i,
    input wire logic [tcp_pkg::CNT_W-1:0] modulo_limit_i,
    input wire logic fixed_clock_tick_i,
    input wire logic external_count_clock_i,
    // Counter access
    input wire logic counter_write_i,
    output logic [tcp_pkg::CNT_W-1:0] counter_value_o,
    output logic counter_down_o,
    // Overflow flag
    input wire logic overflow_clear_i,
    output logic overflow_flag_o,
    // Channel configuration
    input wire logic [tcp_pkg::CH_NUM-1:0][1:0] channel_mode_select_i,
    input wire logic [tcp_pkg::CH_NUM-1:0][1:0] edge_level_select_i,
    // Channel value access
    input wire logic [tcp_pkg::CH_NUM-1:0] value_write_i,
    input wire logic [tcp_pkg::CH_NUM-1:0][tcp_pkg::CNT_W-1:0]
        value_wdata_i,
    output logic [tcp_pkg::CH_NUM-1:0][tcp_pkg::CNT_W-1:0]
        channel_compare_value_o,
    output logic [tcp_pkg::CH_NUM-1:0][tcp_pkg::CNT_W-1:0]
        channel_pending_value_o,
    // Channel flags
    input wire logic [tcp_pkg::CH_NUM-1:0] channel_flag_clear_i,
    output logic [tcp_pkg::CH_NUM-1:0] channel_flag_o,
    // Channel pins
    input wire logic [tcp_pkg::CH_NUM-1:0] timer_channel_pin_i,
    output logic [tcp_pkg::CH_NUM-1:0] timer_channel_pin_o,
    output logic [tcp_pkg::CH_NUM-1:0] timer_channel_pin_oe_o
);
    import tcp_pkg::*;
    logic run;
    logic tick;
    logic free_run;
    logic [CNT_W-1:0] top;
    logic [CNT_W-1:0] top_less;
    logic load;
    logic ovf_evt;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic up_q, up_d;
    logic step_q, step_d;
    logic step_up_q, step_up_d;
    logic ovf_q, ovf_d;
    logic clk_on;
    logic at_top;
    logic at_zero;

    // Wait mode is deliberately not an input: nothing stops there
    assign run = !debug_halt_mode_i && !stop_mode_i;
    assign clk_on = clock_source_select_i != CLK_OFF;

    tcp_prescaler u_prescaler (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .clock_source_select_i(clock_source_select_i),
        .prescale_select_i(prescale_select_i),
        .fixed_clock_tick_i(fixed_clock_tick_i),
        .external_count_clock_i(external_count_clock_i),
        .run_i(run),
        // Restart so the period after a write is whole
        .restart_i(counter_write_i),
        .count_tick_o(tick)
    );

    always_comb
    begin
        free_run = (modulo_limit_i == CNT_ZERO)
            || (modulo_limit_i == CNT_FULL);
        top = free_run ? CNT_FULL : modulo_limit_i;
        top_less = top - CNT_ONE;
        at_top = cnt_q >= top;
        at_zero = cnt_q == CNT_ZERO;
        cnt_d = cnt_q;
        up_d = up_q;
        step_d = 1'b0;
        step_up_d = step_up_q;
        ovf_evt = 1'b0;
        load = 1'b0;
        if (counter_write_i)
        begin
            cnt_d = CNT_ZERO;
            up_d = 1'b1;
            step_up_d = 1'b1;
        end
        else if (tick)
        begin
            step_d = 1'b1;
            if (center_align_select_i)
            begin
                if (up_q && at_top)
                begin
                    up_d = 1'b0;
                    cnt_d = cnt_q - CNT_ONE;
                    step_up_d = 1'b0;
                    ovf_evt = 1'b1;
                end
                else if (up_q)
                begin
                    cnt_d = cnt_q + CNT_ONE;
                    step_up_d = 1'b1;
                    load = cnt_q == top_less;
                end
                else if (at_zero)
                begin
                    up_d = 1'b1;
                    cnt_d = cnt_q + CNT_ONE;
                    step_up_d = 1'b1;
                end
                else
                begin
                    cnt_d = cnt_q - CNT_ONE;
                    step_up_d = 1'b0;
                end
            end
            else
            begin
                up_d = 1'b1;
                step_up_d = 1'b1;
                load = cnt_q == top_less;
                // A limit lowered below the count also wraps
                if (at_top)
                begin
                    cnt_d = CNT_ZERO;
                    ovf_evt = 1'b1;
                end
                else
                begin
                    cnt_d = cnt_q + CNT_ONE;
                end
            end
        end
        // Set beats a clear in the same cycle
        ovf_d = ovf_evt || (ovf_q && !overflow_clear_i);
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_q <= CNT_ZERO;
            up_q <= 1'b1;
            step_q <= 1'b0;
            step_up_q <= 1'b1;
            ovf_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            up_q <= up_d;
            step_q <= step_d;
            step_up_q <= step_up_d;
            ovf_q <= ovf_d;
        end
    end

    assign counter_value_o = cnt_q;
    assign counter_down_o = !up_q;
    assign overflow_flag_o = ovf_q;

    genvar g;
    generate
        for (g = 0; g < CH_NUM; g++)
        begin : g_chan
            logic rise;
            logic fall;
            logic [1:0] els;
            logic [1:0] ms;
            logic pol;
            logic drive;
            logic is_cap;
            logic is_cmp;
            logic is_edge_pwm;
            logic pwm_mode;
            logic match;
            logic cap_ev;
            logic set_flag;
            logic period_start;
            logic [CNT_W-1:0] val_q, val_d;
            logic [CNT_W-1:0] buf_q, buf_d;
            logic pin_q, pin_d;
            logic flag_q, flag_d;

            tcp_edge_sync u_pin_sync (
                .core_clk_i(core_clk_i),
                .arst_n_i(arst_n_i),
                .pin_i(timer_channel_pin_i[g]),
                .rise_o(rise),
                .fall_o(fall)
            );

            always_comb
            begin
                els = edge_level_select_i[g];
                ms = channel_mode_select_i[g];
                pol = els[ELS_POL_BIT];
                drive = (els != ELS_NONE) && clk_on;
                is_cap = !center_align_select_i
                    && (ms == MODE_CAPTURE) && (els != ELS_NONE);
                is_cmp = !center_align_select_i && ((ms == MODE_COMPARE)
                    || ((ms == MODE_CAPTURE) && (els == ELS_NONE)));
                is_edge_pwm = !center_align_select_i && ms[MODE_PWM_BIT];
                pwm_mode = center_align_select_i || is_edge_pwm;
                match = step_q && (cnt_q == val_q);
                period_start = step_q && at_zero;
                cap_ev = 1'b0;
                unique case (els)
                    ELS_NONE: cap_ev = 1'b0;
                    ELS_RISE_TOGGLE: cap_ev = rise;
                    ELS_FALL_CLEAR: cap_ev = fall;
                    ELS_BOTH_SET: cap_ev = rise || fall;
                endcase
                cap_ev = cap_ev && is_cap && !stop_mode_i;
                buf_d = value_write_i[g] ? value_wdata_i[g] : buf_q;
                val_d = val_q;
                // Capture beats a value write in the same cycle
                if (cap_ev)
                begin
                    val_d = cnt_q;
                end
                else if (pwm_mode)
                begin
                    if (load)
                    begin
                        val_d = buf_q;
                    end
                end
                else if (value_write_i[g])
                begin
                    val_d = value_wdata_i[g];
                end
                pin_d = pin_q;
                set_flag = cap_ev;
                if (is_cmp && match)
                begin
                    set_flag = 1'b1;
                    // Toggle starts from the level last driven
                    unique case (els)
                        ELS_NONE: pin_d = pin_q;
                        ELS_RISE_TOGGLE: pin_d = !pin_q;
                        ELS_FALL_CLEAR: pin_d = 1'b0;
                        ELS_BOTH_SET: pin_d = 1'b1;
                    endcase
                end
                if (is_edge_pwm)
                begin
                    // Period start first so a zero value means 0 %
                    if (period_start)
                    begin
                        pin_d = !pol;
                    end
                    if (match)
                    begin
                        pin_d = pol;
                        set_flag = 1'b1;
                    end
                end
                // Direction of the step just taken decides
                if (center_align_select_i && match)
                begin
                    set_flag = 1'b1;
                    pin_d = step_up_q ? pol : !pol;
                end
                flag_d = set_flag || (flag_q && !channel_flag_clear_i[g]);
            end

            always_ff @(posedge core_clk_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                begin
                    val_q <= CNT_ZERO;
                    buf_q <= CNT_ZERO;
                    pin_q <= 1'b0;
                    flag_q <= 1'b0;
                end
                else
                begin
                    val_q <= val_d;
                    buf_q <= buf_d;
                    pin_q <= pin_d;
                    flag_q <= flag_d;
                end
            end

            assign channel_compare_value_o[g] = val_q;
            assign channel_pending_value_o[g] = buf_q;
            assign channel_flag_o[g] = flag_q;
            assign timer_channel_pin_o[g] = pin_q;
            assign timer_channel_pin_oe_o[g] = drive && !is_cap;
        end
    endgenerate
endmodule

// File: tb/tcp_timer_monitor.sv
`timescale 1ns/1ps
module tcp_timer_monitor (
    // Clock, reset, processor state
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic debug_halt_mode_i,
    input wire logic stop_mode_i,
    // Configuration
    input wire tcp_pkg::tcp_clk_src_t clock_source_select_i,
    input wire logic center_align_select_i,
    input wire logic [tcp_pkg::CNT_W-1:0] modulo_limit_i,
    input wire logic [tcp_pkg::CH_NUM-1:0][1:0] channel_mode_select_i,
    input wire logic [tcp_pkg::CH_NUM-1:0][1:0] edge_level_select_i,
    // Counter, flags, pins
    input wire logic counter_write_i,
    input wire logic [tcp_pkg::CNT_W-1:0] counter_value_o,
    input wire logic counter_down_o,
    input wire logic overflow_flag_o,
    input wire logic [tcp_pkg::CH_NUM-1:0] channel_flag_clear_i,
    input wire logic [tcp_pkg::CH_NUM-1:0] channel_flag_o,
    input wire logic [tcp_pkg::CH_NUM-1:0] timer_channel_pin_oe_o
);
    import tcp_pkg::*;
    logic [CH_NUM-1:0] oe_exp;
    always_comb
    begin
        for (int k = 0; k < CH_NUM; k++)
        begin
            oe_exp[k] = (edge_level_select_i[k] != ELS_NONE)
                && (clock_source_select_i != CLK_OFF)
                && (center_align_select_i
                || channel_mode_select_i[k] != MODE_CAPTURE);
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Counter writes excluded: they move the count on their own
    sequence s_edge_wrap;
        !center_align_select_i && !$past(center_align_select_i)
        && modulo_limit_i != CNT_ZERO && modulo_limit_i != CNT_FULL
        && $past(counter_value_o) == modulo_limit_i
        && $changed(counter_value_o) && !$past(counter_write_i);
    endsequence
    a_halt_freeze: assert property (
        debug_halt_mode_i && $past(debug_halt_mode_i) && !counter_write_i
        |=> $stable(counter_value_o)) else $error("count moved in halt");
    a_stop_freeze: assert property (
        stop_mode_i && $past(stop_mode_i) && !counter_write_i
        |=> $stable(counter_value_o)) else $error("count moved in stop");
    a_write_clears_count: assert property (
        counter_write_i |=> counter_value_o == CNT_ZERO && !counter_down_o)
        else $error("counter write did not clear");
    a_edge_wrap: assert property (
        s_edge_wrap |-> counter_value_o == CNT_ZERO)
        else $error("edge count left top not to zero");
    a_ovf_on_wrap: assert property (
        s_edge_wrap |-> overflow_flag_o) else $error("no overflow at wrap");
    a_free_run_step: assert property (
        !center_align_select_i && !$past(center_align_select_i)
        && (modulo_limit_i == CNT_ZERO || modulo_limit_i == CNT_FULL)
        && !$past(counter_write_i) && $changed(counter_value_o)
        && $past(counter_value_o) != CNT_FULL
        |-> counter_value_o == $past(counter_value_o) + CNT_ONE)
        else $error("free count did not step by one");
    a_center_top_turn: assert property (
        center_align_select_i && $past(center_align_select_i)
        && modulo_limit_i != CNT_ZERO && !$past(counter_write_i)
        && $past(counter_value_o) == modulo_limit_i
        && $changed(counter_value_o)
        |-> counter_value_o == modulo_limit_i - CNT_ONE)
        else $error("center count did not turn down at top");
    a_center_bottom_turn: assert property (
        center_align_select_i && $past(center_align_select_i)
        && $past(counter_value_o) == CNT_ZERO && !$past(counter_write_i)
        && $changed(counter_value_o) |-> counter_value_o == CNT_ONE)
        else $error("center count did not turn up at zero");
    a_flag_sticky: assert property (
        (|($past(channel_flag_o) & ~channel_flag_o
        & ~$past(channel_flag_clear_i))) == 1'b0)
        else $error("channel flag fell without clear");
    a_oe_config: assert property (
        timer_channel_pin_oe_o == oe_exp) else $error("pin enable wrong");
    c_center_down: cover property (center_align_select_i && counter_down_o);
    c_overflow: cover property ($rose(overflow_flag_o));
    c_chan_flag: cover property ($rose(|channel_flag_o));
endmodule
bind tcp_timer tcp_timer_monitor i_mon (.core_clk_i, .arst_n_i,
    .debug_halt_mode_i, .stop_mode_i, .clock_source_select_i,
    .center_align_select_i, .modulo_limit_i, .channel_mode_select_i,
    .edge_level_select_i, .counter_write_i, .counter_value_o,
    .counter_down_o, .overflow_flag_o, .channel_flag_clear_i,
    .channel_flag_o, .timer_channel_pin_oe_o);

// File: tb/tcp_pin_model.sv
`timescale 1ns/1ps
module tcp_pin_model (
    // Clock
    input wire logic core_clk_i,
    // Pin wires
    input wire logic [7:0] oe_i,
    input wire logic [7:0] dut_pin_i,
    input wire logic [7:0] level_i,
    output logic [7:0] pin_o,
    // External count clock
    input wire logic ext_run_i,
    output logic ext_clk_o
);
    logic [1:0] div_q = 2'h0;
    logic ext_q = 1'b0;
    // Driven pins win, others follow the outside circuit
    assign pin_o = (oe_i & dut_pin_i) | (~oe_i & level_i);
    assign ext_clk_o = ext_q;
    // One eighth of core rate, still outside bursts
    always_ff @(posedge core_clk_i)
    begin
        if (ext_run_i)
        begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3)
                ext_q <= ~ext_q;
        end
    end
endmodule

// File: tb/tb_tcp_timer.sv
`timescale 1ns/1ps
module tb_tcp_timer;
    import tcp_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, dbg = 1'b0, stp = 1'b0, ctr = 1'b0;
    logic cwr = 1'b0, oclr = 1'b0, ext_run = 1'b0, down, ovf, ext;
    logic fix = 1'b0;
    tcp_clk_src_t src = CLK_OFF;
    logic [PS_W-1:0] ps = 3'h0;
    logic [CNT_W-1:0] md = 16'h0000, cnt, h, d;
    logic [CH_NUM-1:0][1:0] msel = 16'h0000, els = 16'h0000;
    logic [CH_NUM-1:0] vwr = 8'h00, fclr = 8'h00, lvl = 8'h00;
    logic [CH_NUM-1:0] flag, pin, oe, pin_in;
    logic [CH_NUM-1:0][CNT_W-1:0] vwd = 128'h0, cv, pv;
    int err_count = 0, n_compared = 0, t;
    always #4 clk = ~clk;
    tcp_timer i_dut (.core_clk_i(clk), .arst_n_i(rst_n),
        .debug_halt_mode_i(dbg), .stop_mode_i(stp),
        .clock_source_select_i(src), .prescale_select_i(ps),
        .center_align_select_i(ctr), .modulo_limit_i(md),
        .fixed_clock_tick_i(fix), .external_count_clock_i(ext),
        .counter_write_i(cwr), .counter_value_o(cnt), .counter_down_o(down),
        .overflow_clear_i(oclr), .overflow_flag_o(ovf),
        .channel_mode_select_i(msel), .edge_level_select_i(els),
        .value_write_i(vwr), .value_wdata_i(vwd),
        .channel_compare_value_o(cv), .channel_pending_value_o(pv),
        .channel_flag_clear_i(fclr), .channel_flag_o(flag),
        .timer_channel_pin_i(pin_in), .timer_channel_pin_o(pin),
        .timer_channel_pin_oe_o(oe));
    tcp_pin_model i_pins (.core_clk_i(clk), .oe_i(oe), .dut_pin_i(pin),
        .level_i(lvl), .pin_o(pin_in), .ext_run_i(ext_run), .ext_clk_o(ext));
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e)
        begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task wait_cnt(input logic [15:0] v, input logic dn);
        t = 0;
        do
        begin
            step(1);
            t++;
            if (t > 700)
            begin
                chk("wait timeout", 16'(t), 16'h0000);
                summarize();
            end
        end while (!(cnt === v && down === dn));
    endtask
    // Write held over two edges so no step sees a half-changed limit
    task cfg(input logic [15:0] m);
        cwr = 1'b1;
        step(1);
        md = m;
        step(1);
        cwr = 1'b0;
    endtask
    task wr(input int c, input logic [15:0] v);
        vwd[c] = v;
        vwr[c] = 1'b1;
        step(1);
        vwr[c] = 1'b0;
    endtask
    task clr(input int c);
        fclr[c] = 1'b1;
        step(1);
        fclr[c] = 1'b0;
    endtask
    task t_count;
        chk("reset oe", oe, 8'h00);
        chk("reset flags", flag, 8'h00);
        cfg(16'h0003);
        src = CLK_BUS;
        wait_cnt(16'h0000, 1'b0);
        wait_cnt(16'h0000, 1'b0);
        chk("period", 16'(t), md + 16'h1);
        chk("overflow", ovf, 1'b1);
        oclr = 1'b1;
        step(1);
        oclr = 1'b0;
        chk("ovf clear", ovf, 1'b0);
        dbg = 1'b1;
        step(2);
        h = cnt;
        step(5);
        chk("halt", cnt, h);
        dbg = 1'b0;
        stp = 1'b1;
        step(2);
        h = cnt;
        step(5);
        chk("stop", cnt, h);
        stp = 1'b0;
        step(3);
        chk("resume", cnt != h, 1'b1);
        cwr = 1'b1;
        step(1);
        cwr = 1'b0;
        chk("write", cnt, 16'h0000);
        $display("t_count done");
    endtask
    task t_prescale;
        cfg(16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            ps = 3'(i);
            h = cnt;
            wait_cnt(h + 16'h1, 1'b0);
            wait_cnt(h + 16'h2, 1'b0);
            chk("divide", 16'(t), 16'(1 << i));
        end
        ps = 3'h0;
        src = CLK_EXT;
        ext_run = 1'b1;
        h = cnt;
        wait_cnt(h + 16'h1, 1'b0);
        wait_cnt(h + 16'h2, 1'b0);
        chk("ext clock", 16'(t), 16'h0008);
        ext_run = 1'b0;
        src = CLK_FIXED;
        h = cnt;
        step(8);
        chk("fixed idle", cnt, h);
        fix = 1'b1;
        wait_cnt(h + 16'h1, 1'b0);
        wait_cnt(h + 16'h2, 1'b0);
        chk("fixed clock", 16'(t), 16'h0001);
        fix = 1'b0;
        src = CLK_BUS;
        $display("t_prescale done");
    endtask
    task t_compare;
        cfg(16'h0007);
        msel[0] = MODE_COMPARE;
        wr(0, 16'h0004);
        for (int e = 0; e < 4; e++)
        begin
            els[0] = 2'(e);
            clr(0);
            wait_cnt(16'h0006, 1'b0);
            chk("cmp flag", flag[0], 1'b1);
            chk("cmp oe", oe[0], e != 0);
            chk("cmp pin", pin[0], 4'b1010 >> e & 1);
        end
        els[0] = ELS_NONE;
        $display("t_compare done");
    endtask
    task t_capture;
        cfg(16'h00ff);
        for (int e = 0; e < 4; e++)
        begin
            els[1] = 2'(e);
            step(8);
            clr(1);
            lvl[1] = 1'b1;
            h = cnt;
            step(8);
            chk("cap rise", flag[1], e & 1);
            chk("cap oe", oe[1], 1'b0);
            d = cv[1] - h;
            if (e & 1)
                chk("cap value", d >= 16'h2 && d <= 16'h5, 1'b1);
            clr(1);
            lvl[1] = 1'b0;
            step(8);
            chk("cap fall", flag[1], e >> 1);
        end
        $display("t_capture done");
    endtask
    task t_edge_pwm;
        cfg(16'h0007);
        msel[2] = 2'b10;
        msel[3] = 2'b10;
        els[2] = ELS_FALL_CLEAR;
        els[3] = ELS_RISE_TOGGLE;
        wr(2, 16'h0003);
        wr(3, 16'h0003);
        oclr = 1'b1;
        step(1);
        oclr = 1'b0;
        chk("ovf cleared", ovf, 1'b0);
        wait_cnt(16'h0007, 1'b0);
        wait_cnt(16'h0001, 1'b0);
        chk("pwm high", pin[2], 1'b1);
        chk("pwm low-true", pin[3], 1'b0);
        clr(2);
        wait_cnt(16'h0004, 1'b0);
        chk("pwm match", pin[2], 1'b0);
        chk("pwm inv", pin[3], 1'b1);
        chk("pwm flag", flag[2], 1'b1);
        chk("pwm ovf", ovf, 1'b1);
        wr(2, 16'h0005);
        chk("buffered", cv[2], 16'h0003);
        chk("pending", pv[2], 16'h0005);
        wait_cnt(16'h0001, 1'b0);
        chk("loaded", cv[2], 16'h0005);
        $display("t_edge_pwm done");
    endtask
    task t_center_pwm;
        msel = 16'h0000;
        els = 16'h0000;
        els[4] = ELS_FALL_CLEAR;
        ctr = 1'b1;
        wr(4, 16'h0002);
        cfg(16'h0006);
        wait_cnt(16'h0005, 1'b1);
        wait_cnt(16'h0001, 1'b1);
        chk("center_pwm set", pin[4], 1'b1);
        chk("center_pwm oe", oe[4], 1'b1);
        wait_cnt(16'h0003, 1'b0);
        chk("center_pwm clear", pin[4], 1'b0);
        wait_cnt(16'h0003, 1'b0);
        chk("center_pwm period", 16'(t), 2 * md);
        ctr = 1'b0;
        $display("t_center_pwm done");
    endtask
    initial
    begin
        step(2);
        rst_n = 1'b1;
        step(1);
        t_count();
        t_prescale();
        t_compare();
        t_capture();
        t_edge_pwm();
        t_center_pwm();
        summarize();
    end
endmodule
